// ==== hw/ascpc_pkg.sv ====
`default_nettype none
package ascpc_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_SCAN_LOW        = 8'h00;
    localparam logic [7:0] OFF_SCAN_HIGH       = 8'h04;
    localparam logic [7:0] OFF_PIN_MODE_LOW    = 8'h08;
    localparam logic [7:0] OFF_PIN_MODE_HIGH   = 8'h0C;
    localparam logic [7:0] OFF_SCAN2_LOW       = 8'h10;
    localparam logic [7:0] OFF_PIN_MODE2_LOW   = 8'h14;
    localparam logic [7:0] OFF_CONTROL         = 8'h18;
    localparam logic [7:0] OFF_STATUS          = 8'h1C;

    // reset values
    localparam logic [15:0] RST_SEL_REG        = 16'h0000;
    localparam logic [31:0] RST_CONTROL        = 32'h0000_0000;

    // control field positions
    localparam int CTL_SCAN_EN1   = 0;
    localparam int CTL_SCAN_EN2   = 1;
    localparam int CTL_OFF1       = 2;
    localparam int CTL_OFF2       = 3;
    localparam int CTL_FIX1_LSB   = 8;
    localparam int CTL_FIX2_LSB   = 16;

    // status field positions
    localparam int STS_CHAN1_LSB  = 0;
    localparam int STS_CHAN2_LSB  = 8;
    localparam int STS_LOWREF1    = 16;
    localparam int STS_LOWREF2    = 17;

    // input counts
    localparam int ALL_INPUTS     = 32;
    localparam int LOW_INPUTS     = 16;

    // input selection handed to a converter's multiplexer
    typedef struct packed {
        logic [4:0] chan;
        logic       lowRef;
    } ascpc_conv_sel_type;

endpackage
`default_nettype wire

// ==== hw/ascpc_pin_scan.sv ====
// Operation
// - A scan includes an input whose scan-pick bit is 1 and skips it when the bit is 0.
// - Low scan-select bit x selects analog input x for inputs 0 to 15.
// - High scan-select bit x selects analog input 16+x, covering inputs 16 to 31.
// - All high scan-select bits are writable; a selected absent input samples the low reference.
// - A pin-mode bit of 1 makes the pin digital, read input on, converter input grounded.
// - A pin-mode bit of 0 makes the pin analog, read input off, converter samples the pin.
// - All pin-mode bits read and write on every part; bits of absent inputs do nothing.
// - High pin-mode bits govern inputs 16 to 31 and low bits inputs 0 to 15, one bit each.
// - The second converter has only inputs 0 to 15 and no high pin-mode register.
// - With two converters both low pin-mode registers act on the pins of inputs 0 to 15.
// - A converter switched off ignores pin-mode bits and its shared pins go digital.
// - With scan disabled only the fixed channel selection is used.
// - The second converter accepts only inputs 0 to 15 as positive input.
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

module ascpc_pin_scan #(
    parameter int NUM_INPUTS = 32,
    parameter bit DUAL       = 1'b1
) (
    // clock and reset
    input  wire logic                         core_clk,
    input  wire logic                         sys_rst,
    // apb slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [7:0]                   paddr,
    input  wire logic [31:0]                  pwdata,
    output logic                              pready,
    output logic [31:0]                       prdata,
    output logic                              pslverr,
    // converter sequencing strobes
    input  wire logic                         convStep1,
    input  wire logic                         convStep2,
    // converter input selections
    output ascpc_pkg::ascpc_conv_sel_type     convSel1,
    output ascpc_pkg::ascpc_conv_sel_type     convSel2,
    // shared pin control
    output logic [31:0]                       portReadEn,
    output logic [31:0]                       muxGround
);

    // refuse input counts that the 32-bit masks cannot serve
    if (NUM_INPUTS < 1 || NUM_INPUTS > ascpc_pkg::ALL_INPUTS) begin : g_bad_count
        $error("NUM_INPUTS must lie in 1 to 32");
    end

    localparam int LOW_PRESENT =
        (NUM_INPUTS < ascpc_pkg::LOW_INPUTS) ? NUM_INPUTS : ascpc_pkg::LOW_INPUTS;

    // first set mask bit from start upward, wrapping; start when mask is empty
    function automatic logic [4:0] firstFrom(input logic [31:0] mask,
                                             input logic [4:0] start);
        logic [4:0] idx;
        logic       found;
        firstFrom = start;
        found = 1'b0;
        for (int i = 0; i < 32; i++) begin
            idx = start + i[4:0];
            if (!found && mask[idx]) begin
                firstFrom = idx;
                found = 1'b1;
            end
        end
    endfunction

    logic [15:0] scanLow_r;
    logic [15:0] scanHigh_r;
    logic [15:0] pinLow_r;
    logic [15:0] pinHigh_r;
    logic [15:0] scan2Low_r;
    logic [15:0] pin2Low_r;
    logic [31:0] control_r;
    logic [4:0]  ptr1_r;
    logic [3:0]  ptr2_r;
    logic        pready_r;
    logic [31:0] prdata_r;
    logic        pslverr_r;
    ascpc_pkg::ascpc_conv_sel_type sel1_r;
    ascpc_pkg::ascpc_conv_sel_type sel2_r;
    logic [31:0] readEn_r;
    logic [31:0] ground_r;

    // bus decode
    wire logic accessEnd = psel && penable && pready_r;
    wire logic doWrite   = accessEnd && pwrite;
    wire logic hitScanL  = paddr == ascpc_pkg::OFF_SCAN_LOW;
    wire logic hitScanH  = paddr == ascpc_pkg::OFF_SCAN_HIGH;
    wire logic hitPinL   = paddr == ascpc_pkg::OFF_PIN_MODE_LOW;
    wire logic hitPinH   = paddr == ascpc_pkg::OFF_PIN_MODE_HIGH;
    wire logic hitScan2  = DUAL && paddr == ascpc_pkg::OFF_SCAN2_LOW;
    wire logic hitPin2   = DUAL && paddr == ascpc_pkg::OFF_PIN_MODE2_LOW;
    wire logic hitCtl    = paddr == ascpc_pkg::OFF_CONTROL;
    wire logic hitSts    = paddr == ascpc_pkg::OFF_STATUS;
    wire logic hitAny    = hitScanL | hitScanH | hitPinL | hitPinH
                         | hitScan2 | hitPin2 | hitCtl | hitSts;

    // write strobes, one per writable register, none for status
    wire logic wrScanL   = doWrite && hitScanL;
    wire logic wrScanH   = doWrite && hitScanH;
    wire logic wrPinL    = doWrite && hitPinL;
    wire logic wrPinH    = doWrite && hitPinH;
    wire logic wrScan2   = doWrite && hitScan2;
    wire logic wrPin2    = doWrite && hitPin2;
    wire logic wrCtl     = doWrite && hitCtl;

    // control fields
    wire logic       scanEn1 = control_r[ascpc_pkg::CTL_SCAN_EN1];
    wire logic       scanEn2 = DUAL && control_r[ascpc_pkg::CTL_SCAN_EN2];
    wire logic       off1    = control_r[ascpc_pkg::CTL_OFF1];
    wire logic       off2    = DUAL && control_r[ascpc_pkg::CTL_OFF2];
    wire logic [4:0] fix1    = control_r[ascpc_pkg::CTL_FIX1_LSB +: 5];
    wire logic [3:0] fix2    = control_r[ascpc_pkg::CTL_FIX2_LSB +: 4];

    wire logic [31:0] mask1 = {scanHigh_r, scanLow_r};
    wire logic [31:0] mask2 = {16'h0000, scan2Low_r};

    wire logic [4:0] cur1   = firstFrom(mask1, ptr1_r);
    wire logic [4:0] next1  = firstFrom(mask1, cur1 + 5'h01);
    wire logic [4:0] cur2w  = firstFrom(mask2, {1'b0, ptr2_r});
    wire logic [4:0] next2w = firstFrom(mask2, {1'b0, cur2w[3:0]} + 5'h01);

    wire logic [4:0] chan1 = scanEn1 ? cur1 : fix1;
    wire logic [3:0] chan2 = scanEn2 ? cur2w[3:0] : fix2;

    // absent input converts the low reference
    wire logic absent1 = 32'(chan1) >= 32'(NUM_INPUTS);
    wire logic absent2 = 32'(chan2) >= 32'(LOW_PRESENT);

    // status image of both current selections
    logic [31:0] status;
    always_comb begin
        status                                = 32'h0000_0000;
        status[ascpc_pkg::STS_CHAN1_LSB +: 5] = sel1_r.chan;
        status[ascpc_pkg::STS_CHAN2_LSB +: 5] = sel2_r.chan;
        status[ascpc_pkg::STS_LOWREF1]        = sel1_r.lowRef;
        status[ascpc_pkg::STS_LOWREF2]        = sel2_r.lowRef;
    end

    // control image keeps only the defined fields, the rest read 0
    logic [31:0] control_nxt;
    always_comb begin
        control_nxt                               = 32'h0000_0000;
        control_nxt[ascpc_pkg::CTL_SCAN_EN1]      = pwdata[ascpc_pkg::CTL_SCAN_EN1];
        control_nxt[ascpc_pkg::CTL_SCAN_EN2]      = pwdata[ascpc_pkg::CTL_SCAN_EN2];
        control_nxt[ascpc_pkg::CTL_OFF1]          = pwdata[ascpc_pkg::CTL_OFF1];
        control_nxt[ascpc_pkg::CTL_OFF2]          = pwdata[ascpc_pkg::CTL_OFF2];
        control_nxt[ascpc_pkg::CTL_FIX1_LSB +: 5] = pwdata[ascpc_pkg::CTL_FIX1_LSB +: 5];
        control_nxt[ascpc_pkg::CTL_FIX2_LSB +: 4] = pwdata[ascpc_pkg::CTL_FIX2_LSB +: 4];
    end

    // every pin-mode bit reads back as written
    wire logic [31:0] readMux =
          hitScanL ? {16'h0000, scanLow_r}
        : hitScanH ? {16'h0000, scanHigh_r}
        : hitPinL  ? {16'h0000, pinLow_r}
        : hitPinH  ? {16'h0000, pinHigh_r}
        : hitScan2 ? {16'h0000, scan2Low_r}
        : hitPin2  ? {16'h0000, pin2Low_r}
        : hitCtl   ? control_r
        : hitSts   ? status
        : 32'h0000_0000;

    // per-pin mode
    genvar gp;
    for (gp = 0; gp < 32; gp++) begin : g_pin
        logic want1;
        logic want2;
        logic digital;
        // pin-mode bit per input, forced digital when off
        assign want1 = off1 | ((gp < 16) ? pinLow_r[gp % 16] : pinHigh_r[gp % 16]);
        // second converter acts on low pins
        assign want2 = (gp < 16) && DUAL && (off2 | pin2Low_r[gp % 16]);
        assign digital = want1 | want2;
        always_ff @(posedge core_clk) begin
            if (sys_rst) begin
                readEn_r[gp] <= 1'b0;
                ground_r[gp] <= 1'b0;
            end else if (gp >= NUM_INPUTS) begin
                readEn_r[gp] <= 1'b0;
                ground_r[gp] <= 1'b1;
            end else begin
                // digital grounds the mux input, analog samples the pin
                readEn_r[gp] <= digital;
                ground_r[gp] <= digital;
            end
        end
    end

    // apb answer one cycle into the access phase
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= psel && penable && !pready_r;
            prdata_r  <= (psel && penable && !pwrite && !pready_r) ? readMux : 32'h0000_0000;
            pslverr_r <= psel && penable && !pready_r && !hitAny;
        end
    end

    // register writes, one short block per writable register, none for status
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            scanLow_r <= ascpc_pkg::RST_SEL_REG;
        end else if (wrScanL) begin
            scanLow_r <= pwdata[15:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            scanHigh_r <= ascpc_pkg::RST_SEL_REG;
        end else if (wrScanH) begin
            scanHigh_r <= pwdata[15:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pinLow_r <= ascpc_pkg::RST_SEL_REG;
        end else if (wrPinL) begin
            pinLow_r <= pwdata[15:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pinHigh_r <= ascpc_pkg::RST_SEL_REG;
        end else if (wrPinH) begin
            pinHigh_r <= pwdata[15:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            scan2Low_r <= ascpc_pkg::RST_SEL_REG;
        end else if (wrScan2) begin
            scan2Low_r <= pwdata[15:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            pin2Low_r <= ascpc_pkg::RST_SEL_REG;
        end else if (wrPin2) begin
            pin2Low_r <= pwdata[15:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            control_r <= ascpc_pkg::RST_CONTROL;
        end else if (wrCtl) begin
            control_r <= control_nxt;
        end
    end

    // scan sequencers advance on each conversion strobe
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            ptr1_r <= 5'h00;
            ptr2_r <= 4'h0;
        end else begin
            if (convStep1 && scanEn1) ptr1_r <= next1;
            if (convStep2 && scanEn2) ptr2_r <= next2w[3:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sel1_r <= '0;
            sel2_r <= '0;
        end else begin
            sel1_r.chan   <= chan1;
            sel1_r.lowRef <= absent1;
            // second converter limited to inputs 0 to 15
            sel2_r.chan   <= DUAL ? {1'b0, chan2} : 5'h00;
            sel2_r.lowRef <= DUAL && absent2;
        end
    end

    assign pready     = pready_r;
    assign prdata     = prdata_r;
    assign pslverr    = pslverr_r;
    assign convSel1   = sel1_r;
    assign convSel2   = sel2_r;
    assign portReadEn = readEn_r;
    assign muxGround  = ground_r;

endmodule

`default_nettype wire

// ==== verif/ascpc_conv_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module ascpc_conv_model (
    // clock and requests
    input  wire logic core_clk,
    input  wire logic go1,
    input  wire logic go2,
    // conversion done strobes
    output logic      convStep1 = 1'b0,
    output logic      convStep2 = 1'b0
);
    // one done pulse per request, a cycle later
    always @(posedge core_clk) begin
        convStep1 <= go1;
        convStep2 <= go2;
    end
endmodule
`default_nettype wire

// ==== verif/ascpc_pin_scan_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module ascpc_pin_scan_props #(
    parameter int NUM_INPUTS = 32
) (
    // bus side
    input wire logic                     core_clk,
    input wire logic                     sys_rst,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [7:0]               paddr,
    input wire logic [31:0]              pwdata,
    input wire logic                     pready,
    input wire logic [31:0]              prdata,
    input wire logic                     pslverr,
    // converter and pin side
    input wire logic                     convStep1,
    input wire logic                     convStep2,
    input wire ascpc_pkg::ascpc_conv_sel_type convSel1,
    input wire ascpc_pkg::ascpc_conv_sel_type convSel2,
    input wire logic [31:0]              portReadEn,
    input wire logic [31:0]              muxGround
);
    logic wrEdge;
    assign wrEdge = psel && penable && pready && pwrite;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        !pready ##1 !pready ##1 pready ##1 !pready;
    endsequence
    a_ready_wait: assert property (s_setup |-> s_answer)
        else $error("bus answer not after one wait state");
    a_err_unmapped: assert property (psel && penable && pready && paddr > 8'h1C |-> pslverr)
        else $error("unmapped access not flagged");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error flag outside answer");
    a_read_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
        else $error("read data outside read answer");
    a_pin_pair: assert property (portReadEn[NUM_INPUTS-1:0] == muxGround[NUM_INPUTS-1:0])
        else $error("read enable and grounding disagree");
    a_chan2_low: assert property (convSel2.chan[4] == 1'b0)
        else $error("second converter above input 15");
    a_sel_hold: assert property (!wrEdge && !$past(wrEdge) && !convStep1 && !$past(convStep1)
                                 |=> $stable(convSel1))
        else $error("selection moved without step");
    a_pins_hold: assert property (!wrEdge && !$past(wrEdge) |=> $stable(portReadEn))
        else $error("pin mode moved without write");
endmodule
bind ascpc_pin_scan ascpc_pin_scan_props #(.NUM_INPUTS(NUM_INPUTS)) u_props (
    .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .convStep1(convStep1),
    .convStep2(convStep2), .convSel1(convSel1), .convSel2(convSel2),
    .portReadEn(portReadEn), .muxGround(muxGround));
`default_nettype wire

// ==== verif/adc_scan_and_pin_config_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module adc_scan_and_pin_config_tb;
    localparam int NIN = 20;
    localparam logic [31:0] M = 32'h000F_FFFF;
    logic core_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic go1 = 1'b0, go2 = 1'b0, convStep1, convStep2, pready, pslverr, e;
    logic [7:0]  paddr = 8'h00;
    logic [15:0] l1, l2, h;
    logic [31:0] pwdata = 32'h0, prdata, portReadEn, muxGround, q, d, rnd = 32'hD03A;
    logic [4:0]  s;
    int          p, failures = 0, comparisons = 0;
    ascpc_pkg::ascpc_conv_sel_type convSel1, convSel2;
    ascpc_pin_scan #(.NUM_INPUTS(NIN)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .convStep1(convStep1),
        .convStep2(convStep2), .convSel1(convSel1), .convSel2(convSel2),
        .portReadEn(portReadEn), .muxGround(muxGround));
    ascpc_conv_model u_model (.core_clk(core_clk), .go1(go1), .go2(go2),
        .convStep1(convStep1), .convStep2(convStep2));
    initial forever #5 core_clk = ~core_clk;
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    // first selected input at or after the pointer, wrapping
    function automatic logic [4:0] nxt(input logic [31:0] m, input int from);
        for (int i = 0; i < 32; i++) if (m[(from + i) % 32]) return 5'((from + i) % 32);
        return 5'h00;
    endfunction
    function automatic logic [31:0] dig(input logic [15:0] a, b, c, input logic [31:0] ctl);
        logic [31:0] r;
        r = {c, a | b};
        if (ctl[3]) r[15:0] = 16'hFFFF;
        if (ctl[2]) r = 32'hFFFF_FFFF;
        return r;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) failures++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic step(input int w);
        if (w == 1) go1 <= 1'b1;
        else go2 <= 1'b1;
        @(posedge core_clk);
        go1 <= 1'b0;
        go2 <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic close_out;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge core_clk);
        failures++;
        close_out;
    end
    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, 8'(i * 4), 32'h0);
            chk(q, 32'h0);
        end
        repeat (4) for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            bus(1'b1, 8'(i * 4), rnd);
            bus(1'b0, 8'(i * 4), 32'h0);
            chk(q, {16'h0, rnd[15:0]});
        end
        bus(1'b1, 8'h24, rnd);
        chk(32'(e), 32'h1);
        bus(1'b0, 8'h24, 32'h0);
        chk(q, 32'h0);
        for (int k = 0; k < 3; k++) begin
            rnd = lfsr(rnd);
            {l1, l2} = rnd;
            rnd = lfsr(rnd);
            h = rnd[15:0];
            bus(1'b1, 8'h08, {16'h0, l1});
            bus(1'b1, 8'h14, {16'h0, l2});
            bus(1'b1, 8'h0C, {16'h0, h});
            bus(1'b1, 8'h18, 32'(k * 4));
            d = dig(l1, l2, h, 32'(k * 4));
            chk(portReadEn, d & M);
            chk(muxGround, d | ~M);
        end
        bus(1'b1, 8'h00, 32'h5);
        bus(1'b1, 8'h04, 32'h8000);
        bus(1'b1, 8'h18, 32'h1);
        p = 0;
        for (int k = 0; k < 4; k++) begin
            s = nxt(32'h8000_0005, p);
            chk(32'(convSel1), 32'({s, s >= NIN}));
            p = (s + 1) % 32;
            step(1);
        end
        bus(1'b1, 8'h18, 32'h1900);
        step(1);
        chk(32'(convSel1), 32'({5'd25, 1'b1}));
        bus(1'b0, 8'h1C, 32'h0);
        chk(q, 32'h0001_0019);
        rnd = lfsr(rnd);
        bus(1'b1, 8'h10, {16'h0, rnd[15:0] | 16'h8000});
        bus(1'b1, 8'h18, 32'h2);
        p = 0;
        for (int k = 0; k < 5; k++) begin
            s = nxt({16'h0, rnd[15:0] | 16'h8000}, p);
            chk(32'(convSel2), 32'({s, 1'b0}));
            p = (s + 1) % 32;
            step(2);
        end
        close_out;
    end
endmodule
`default_nettype wire
